// ---- pkg/ced_pkg.sv ----
// Shared constants, types and register map of the instruction execution block
package ced_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_INSTR  = 8'h00;  // Instruction to execute / last one
  localparam logic [7:0] REG_STATUS = 8'h04;  // Zero, timeout, power-down, busy
  localparam logic [7:0] REG_WACC   = 8'h08;  // Working accumulator
  localparam logic [7:0] REG_PC     = 8'h0C;  // Program counter
  localparam logic [7:0] REG_PCHI   = 8'h10;  // Program counter high latch
  localparam logic [7:0] REG_WDOG   = 8'h14;  // Watchdog counter and prescaler
  localparam logic [7:0] REG_STACK  = 8'h18;  // Stack top and stack pointer
  localparam logic [7:0] REG_FADDR  = 8'h1C;  // File register window address
  localparam logic [7:0] REG_FDATA  = 8'h20;  // File register window data

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int STAT_ZERO_BIT = 0;           // Zero flag
  localparam int STAT_PWRDN_BIT = 1;          // Power-down flag, active low
  localparam int STAT_TMOUT_BIT = 2;          // Timeout flag, active low
  localparam int STAT_BUSY_BIT = 8;           // Instruction in progress
  localparam int INSTR_D_BIT   = 4;           // Destination select
  localparam int INSTR_F_LSB   = 5;           // File address low bit
  localparam int WDOG_PRE_LSB  = 8;           // Prescaler low bit in watchdog reg
  localparam int STACK_SP_LSB  = 16;          // Stack pointer low bit

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int PC_W   = 15;                 // Program counter width
  localparam int FA_W   = 7;                  // File address width
  localparam int INSTR_W = 12;                // Instruction word width
  localparam logic [7:0]       BYTE_ZERO   = 8'h00;  // Cleared byte value
  localparam logic [PC_W-1:0]  PC_RESET    = 15'h0000;
  localparam logic [6:0]       PCHI_RESET   = 7'h00;
  localparam logic             ZERO_RESET  = 1'b0;
  localparam logic             FLAG_N_RESET = 1'b1;  // Timeout / power-down after reset

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CYC_DIV_DEFAULT = 4;         // System clocks per instruction cycle

  // ---------------------------------------------------------------
  // Operation codes held in instruction bits 3:0
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP     = 4'h0,
    OP_WDCLR   = 4'h1,  // watchdog_clear_op
    OP_CALL_ACC = 4'h2,  // call_via_accumulator_op
    OP_COMPL    = 4'h3,  // complement_reg_op
    OP_CLR_REG  = 4'h4,  // clear_reg_op
    OP_DEC_REG  = 4'h5,  // decrement_reg_op
    OP_CLR_ACC  = 4'h6,  // clear_accumulator_op
    OP_DEC_SKIP = 4'h7   // decrement_skip_zero_op
  } ced_op_e;

  // Register access from the bus slave to the core
  typedef struct packed {
    logic        wr;     // One-cycle write strobe
    logic        rd;     // One-cycle read strobe
    logic [7:0]  addr;   // Byte offset
    logic [31:0] wdata;  // Write data
  } ced_busreq_s;

endpackage

// ---- src/ced_ahb_slave.sv ----
// AHB-Lite slave front end turning bus transfers into register strobes
`timescale 1ns/1ps
module ced_ahb_slave (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  output ced_pkg::ced_busreq_s    busReq,
  input  wire logic [31:0]        coreRdata
);

  // ---------------------------------------------------------------
  // Address phase capture
  // ---------------------------------------------------------------
  logic       accept;      // Address phase taken this edge
  logic       pend_q;      // Data phase in progress (wait state)
  logic       wr_q;        // Captured direction
  logic [7:0] addr_q;      // Captured byte offset
  logic [31:0] hrdata_q;   // Read data register
  logic       hready_q;    // Ready out register

  assign accept = hsel & htrans[1] & hready;

  // Strobe to the core during the single wait cycle
  assign busReq.wr    = pend_q & wr_q;
  assign busReq.rd    = pend_q & ~wr_q;
  assign busReq.addr  = addr_q;
  assign busReq.wdata = hwdata;

  // Capture address, insert one wait state, then answer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_q   <= 1'b0;
      wr_q     <= 1'b0;
      addr_q   <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
    end else if (pend_q) begin
      // Data phase: sample read data, release the bus
      pend_q   <= 1'b0;
      hready_q <= 1'b1;
      hrdata_q <= wr_q ? hrdata_q : coreRdata;
    end else if (accept) begin
      // New transfer: hold the bus for one cycle
      pend_q   <= 1'b1;
      wr_q     <= hwrite;
      addr_q   <= haddr[7:0];
      hready_q <= 1'b0;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp     = 1'b0;  // Always OKAY; constant driver

  // Transfer size is always a word here
  logic unusedSize;
  assign unusedSize = ^hsize;

endmodule

// ---- src/ced_exec_core.sv ----
// Execution unit for the watchdog, call, clear, complement and decrement operations
`timescale 1ns/1ps
// What this block does
// - Watchdog clear zeroes counter, sets both flags
// - Watchdog clear also zeroes the prescaler
// - Call via accumulator pushes PC plus one
// - Then PC gets high latch and accumulator
// - Call takes two cycles, flags untouched
// - Complement inverts the addressed file register
// - Destination bit picks accumulator or register
// - Clear register writes zero, sets zero
// - Clear accumulator writes zero, sets zero
// - Decrement subtracts one to chosen destination
// - Decrement-skip skips on zero, flags untouched
module ced_exec_core #(
  parameter int CYC_DIV     = ced_pkg::CYC_DIV_DEFAULT,  // System clocks per cycle
  parameter int STACK_DEPTH = 16,                        // Return stack levels
  parameter int WDOG_W      = 8,                         // Watchdog counter width
  parameter int PRE_W       = 8                          // Prescaler width
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  localparam int SP_W = $clog2(STACK_DEPTH);
  generate
    if (CYC_DIV < 1 || CYC_DIV > 256) begin : gBadDiv
      $error("CYC_DIV must lie between 1 and 256");
    end
    if (STACK_DEPTH < 2 || STACK_DEPTH > 16 || (1 << SP_W) != STACK_DEPTH) begin : gBadStk
      $error("STACK_DEPTH must be a power of two from 2 to 16");
    end
    if (WDOG_W < 1 || WDOG_W > 8 || PRE_W < 1 || PRE_W > 8) begin : gBadWdog
      $error("Watchdog and prescaler widths must lie between 1 and 8");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------
  ced_pkg::ced_busreq_s busReq;     // Register strobes from the slave
  logic [31:0]          coreRdata;  // Read mux result

  ced_ahb_slave uSlave (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .busReq    (busReq),
    .coreRdata (coreRdata)
  );

  // ---------------------------------------------------------------
  // Instruction cycle divider
  // ---------------------------------------------------------------
  logic [7:0] div_q;   // Divider count
  logic       cycEn;   // One-cycle instruction clock enable

  assign cycEn = (div_q == 8'(CYC_DIV - 1));

  // Free-running divider for the instruction clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= 8'h00;
    end else if (cycEn) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Architectural state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} ced_state_e;

  ced_state_e                  state_q;          // Sequencer state
  logic [ced_pkg::INSTR_W-1:0] instr_q;          // Instruction being executed
  logic [7:0]                  wacc_q;           // Working accumulator
  logic [ced_pkg::PC_W-1:0]    pc_q;             // Program counter
  logic [6:0]                  pcHi_q;           // pc_high_latch
  logic                        zero_q;           // Zero flag
  logic                        timeoutN_q;       // timeout_flag_n
  logic                        powerdownN_q;     // powerdown_flag_n
  logic [WDOG_W-1:0]           wdog_q;           // watchdog_counter
  logic [PRE_W-1:0]            pre_q;            // Watchdog prescaler
  logic [SP_W-1:0]             sp_q;             // Next free stack slot
  logic [ced_pkg::PC_W-1:0]    stack_q [STACK_DEPTH];  // Return stack
  logic [7:0]                  file_q [128];     // File registers, one bank
  logic [ced_pkg::FA_W-1:0]    faddr_q;          // Bus window address

  // ---------------------------------------------------------------
  // Instruction decode
  // ---------------------------------------------------------------
  ced_pkg::ced_op_e          op;        // Operation code
  logic                      destReg;   // Destination is the file register
  logic [ced_pkg::FA_W-1:0]  fAddr;     // Operand address
  logic [7:0]                fVal;      // Operand value
  logic [7:0]                decVal;    // Operand minus one
  logic [7:0]                comVal;    // Operand inverted
  logic [7:0]                result;    // Value for the destination
  logic                      resZero;   // Result equals zero
  logic                      writesDst; // Operation delivers to a destination
  logic                      skipTaken; // Decrement-skip reached zero
  logic                      twoCycle;  // Operation needs a second cycle
  logic                      busy;      // Instruction in progress
  logic                      execNow;   // First instruction cycle happens now
  logic                      secondNow; // Second instruction cycle happens now
  logic [ced_pkg::PC_W-1:0]  pcInc;     // Program counter plus one
  logic [ced_pkg::PC_W-1:0]  callDest;  // Target of the accumulator call

  assign op        = ced_pkg::ced_op_e'(instr_q[3:0]);
  assign destReg   = instr_q[ced_pkg::INSTR_D_BIT];
  assign fAddr     = instr_q[ced_pkg::INSTR_F_LSB +: ced_pkg::FA_W];
  assign fVal      = file_q[fAddr];
  assign decVal    = fVal - 8'h01;
  assign comVal    = ~fVal;
  assign result    = (op == ced_pkg::OP_COMPL) ? comVal : decVal;
  assign resZero   = (result == ced_pkg::BYTE_ZERO);
  assign writesDst = (op == ced_pkg::OP_COMPL) || (op == ced_pkg::OP_DEC_REG) ||
                     (op == ced_pkg::OP_DEC_SKIP);
  assign skipTaken = (op == ced_pkg::OP_DEC_SKIP) && resZero;
  assign twoCycle  = (op == ced_pkg::OP_CALL_ACC) || skipTaken;
  assign busy      = (state_q != ST_IDLE);
  assign execNow   = (state_q == ST_EXEC) && cycEn;
  assign secondNow = (state_q == ST_SECOND) && cycEn;
  assign pcInc     = pc_q + 15'h0001;
  assign callDest  = {pcHi_q, wacc_q};

  // Bus writes are taken only while no instruction runs
  logic busWr;   // Accepted register write
  assign busWr = busReq.wr && !busy;

  // Register select, shared by reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Idle until software writes an instruction, then one or two cycles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      instr_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // Launch on an instruction write
          if (busWr && hit(busReq.addr, ced_pkg::REG_INSTR)) begin
            instr_q <= busReq.wdata[ced_pkg::INSTR_W-1:0];
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // Two-cycle operations continue, the rest finish
          if (cycEn) begin
            state_q <= twoCycle ? ST_SECOND : ST_IDLE;
          end
        end
        ST_SECOND: begin
          // Second cycle only updates the PC: call jump or skip step
          if (cycEn) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Program counter and return stack
  // ---------------------------------------------------------------
  // Push happens in the first cycle, the jump in the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_q <= ced_pkg::PC_RESET;
      sp_q <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_q[i] <= ced_pkg::PC_RESET;
      end
    end else if (execNow) begin
      if (op == ced_pkg::OP_CALL_ACC) begin
        stack_q[sp_q] <= pcInc;
        sp_q          <= sp_q + 1'b1;
      end else begin
        pc_q <= pcInc;
      end
    end else if (secondNow) begin
      if (op == ced_pkg::OP_CALL_ACC) begin
        pc_q <= callDest;
      end else begin
        pc_q <= pcInc;
      end
    end else if (busWr && hit(busReq.addr, ced_pkg::REG_PC)) begin
      pc_q <= busReq.wdata[ced_pkg::PC_W-1:0];
    end else if (busWr && hit(busReq.addr, ced_pkg::REG_STACK)) begin
      sp_q <= busReq.wdata[ced_pkg::STACK_SP_LSB +: SP_W];
    end
  end

  // ---------------------------------------------------------------
  // Accumulator and high latch
  // ---------------------------------------------------------------
  // Accumulator takes results whose destination bit is clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wacc_q   <= ced_pkg::BYTE_ZERO;
      pcHi_q   <= ced_pkg::PCHI_RESET;
    end else if (execNow) begin
      if (op == ced_pkg::OP_CLR_ACC) begin
        wacc_q <= ced_pkg::BYTE_ZERO;
      end else if (writesDst && !destReg) begin
        wacc_q <= result;
      end
    end else if (busWr && hit(busReq.addr, ced_pkg::REG_WACC)) begin
      wacc_q <= busReq.wdata[7:0];
    end else if (busWr && hit(busReq.addr, ced_pkg::REG_PCHI)) begin
      pcHi_q   <= busReq.wdata[6:0];
    end
  end

  // ---------------------------------------------------------------
  // File registers
  // ---------------------------------------------------------------
  // Register results land here when the destination bit is set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      faddr_q <= '0;
      for (int i = 0; i < 128; i++) begin
        file_q[i] <= ced_pkg::BYTE_ZERO;
      end
    end else if (execNow) begin
      if (op == ced_pkg::OP_CLR_REG) begin
        file_q[fAddr] <= ced_pkg::BYTE_ZERO;
      end else if (writesDst && destReg) begin
        file_q[fAddr] <= result;
      end
    end else if (busWr && hit(busReq.addr, ced_pkg::REG_FADDR)) begin
      faddr_q <= busReq.wdata[ced_pkg::FA_W-1:0];
    end else if (busWr && hit(busReq.addr, ced_pkg::REG_FDATA)) begin
      file_q[faddr_q] <= busReq.wdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Zero tracks clear, complement and decrement; skip and call leave it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      zero_q       <= ced_pkg::ZERO_RESET;
      timeoutN_q   <= ced_pkg::FLAG_N_RESET;
      powerdownN_q <= ced_pkg::FLAG_N_RESET;
    end else if (execNow) begin
      case (op)
        ced_pkg::OP_CLR_REG, ced_pkg::OP_CLR_ACC: begin
          zero_q <= 1'b1;
        end
        ced_pkg::OP_COMPL, ced_pkg::OP_DEC_REG: begin
          zero_q <= resZero;
        end
        ced_pkg::OP_WDCLR: begin
          timeoutN_q   <= 1'b1;
          powerdownN_q <= 1'b1;
        end
        default: begin
          zero_q <= zero_q;
        end
      endcase
    end else if (busWr && hit(busReq.addr, ced_pkg::REG_STATUS)) begin
      zero_q       <= busReq.wdata[ced_pkg::STAT_ZERO_BIT];
      timeoutN_q   <= busReq.wdata[ced_pkg::STAT_TMOUT_BIT];
      powerdownN_q <= busReq.wdata[ced_pkg::STAT_PWRDN_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Watchdog counter and prescaler
  // ---------------------------------------------------------------
  // Counting lives elsewhere; this holds and clears the values
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wdog_q <= '0;
      pre_q  <= '0;
    end else if (execNow && op == ced_pkg::OP_WDCLR) begin
      wdog_q <= '0;
      pre_q  <= '0;
    end else if (busWr && hit(busReq.addr, ced_pkg::REG_WDOG)) begin
      wdog_q <= busReq.wdata[WDOG_W-1:0];
      pre_q  <= busReq.wdata[ced_pkg::WDOG_PRE_LSB +: PRE_W];
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  logic [SP_W-1:0]          topIdx;    // Most recent stack entry
  logic [ced_pkg::PC_W-1:0] stackTop;  // stack_top value
  logic [31:0]              statusRd;  // Status word
  logic [31:0]              wdogRd;    // Watchdog word
  logic [31:0]              stackRd;   // Stack word

  assign topIdx   = sp_q - 1'b1;
  assign stackTop = stack_q[topIdx];
  assign statusRd = 32'(busy) << ced_pkg::STAT_BUSY_BIT |
                    32'(timeoutN_q) << ced_pkg::STAT_TMOUT_BIT |
                    32'(powerdownN_q) << ced_pkg::STAT_PWRDN_BIT |
                    32'(zero_q) << ced_pkg::STAT_ZERO_BIT;
  assign wdogRd   = 32'(pre_q) << ced_pkg::WDOG_PRE_LSB | 32'(wdog_q);
  assign stackRd  = 32'(sp_q) << ced_pkg::STACK_SP_LSB | 32'(stackTop);

  // Unmapped offsets read as zero
  assign coreRdata =
    hit(busReq.addr, ced_pkg::REG_INSTR)  ? 32'(instr_q)   :
    hit(busReq.addr, ced_pkg::REG_STATUS) ? statusRd       :
    hit(busReq.addr, ced_pkg::REG_WACC)   ? 32'(wacc_q)    :
    hit(busReq.addr, ced_pkg::REG_PC)     ? 32'(pc_q)      :
    hit(busReq.addr, ced_pkg::REG_PCHI)   ? 32'(pcHi_q)    :
    hit(busReq.addr, ced_pkg::REG_WDOG)   ? wdogRd         :
    hit(busReq.addr, ced_pkg::REG_STACK)  ? stackRd        :
    hit(busReq.addr, ced_pkg::REG_FADDR)  ? 32'(faddr_q)   :
    hit(busReq.addr, ced_pkg::REG_FDATA)  ? 32'(file_q[faddr_q]) :
    32'h0000_0000;

endmodule

// ---- verification/ced_exec_chk.sv ----
// Bus timing checker for the instruction execution block
`timescale 1ns/1ps
module ced_exec_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire busTake = hsel && htrans[1] && hready;  // Transfer accepted
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_wait; busTake |=> !hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("no wait cycle");
  property p_back; !hreadyout |=> hreadyout; endproperty
  a_back: assert property (p_back) else $error("wait too long");
  property p_idle; !busTake && hreadyout |=> hreadyout; endproperty
  a_idle: assert property (p_idle) else $error("stray wait");
  property p_hold; hreadyout ##1 hreadyout |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_wrkeep; busTake && hwrite |-> ##2 $stable(hrdata); endproperty
  a_wrkeep: assert property (p_wrkeep) else $error("write moved read data");
  property p_unmap; busTake && !hwrite && haddr[7:0] == 8'h40 |-> ##2 hrdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ready; busTake |-> ##2 hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("transfer not done");
  c_wr: cover property (busTake && hwrite);
  c_rd: cover property (busTake && !hwrite);
  c_launch: cover property (busTake && hwrite && haddr[7:0] == 8'h00);
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the instruction execution block
`timescale 1ns/1ps
module testbench;
  logic        sys_clk   = 1'b0;   // 10 MHz clock
  logic        rst       = 1'b1;   // Active-high reset
  logic        hsel      = 1'b0;   // Slave select
  logic [31:0] haddr     = 32'h0;  // Byte address
  logic [1:0]  htrans    = 2'h0;   // Transfer type
  logic        hwrite    = 1'b0;   // Direction
  logic [31:0] hwdata    = 32'h0;  // Write data
  logic [31:0] hrdata;             // Read data
  logic        hreadyout;          // Slave ready
  logic        hresp;              // Response
  logic [31:0] rv;                 // Last read value
  logic [14:0] expPc     = 15'h0;  // Predicted program counter
  int          num_errors = 0;     // Mismatch count
  int          n_tests    = 0;     // Comparison count
  always #50 sys_clk = ~sys_clk;
  ced_exec_core #(.CYC_DIV(1)) uut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  // Wait for an edge with ready high
  task automatic wt();
    do @(negedge sys_clk); while (hreadyout !== 1'b1);
    @(posedge sys_clk);
  endtask
  // One single word transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask
  // Launch on file 7F and poll busy
  task automatic ex(input ced_pkg::ced_op_e o, input logic d);
    wr(ced_pkg::REG_INSTR, {20'h0, 7'h7F, d, o});
    do xfer(1'b0, ced_pkg::REG_STATUS, 32'h0); while (rv[8] === 1'b1);
    expPc = expPc + 15'h1;
  endtask
  task automatic print_verdict();
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Watchdog against hangs
  initial begin
    #2000000;
    num_errors++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rc(ced_pkg::REG_STATUS, 32'h6, "reset status");
    wr(8'h40, 32'hFFFFFFFF);
    rc(8'h40, 32'h0, "unmapped");
    wr(ced_pkg::REG_WDOG, 32'hA55A);
    wr(ced_pkg::REG_STATUS, 32'h0);
    ex(ced_pkg::OP_WDCLR, 1'b0);
    rc(ced_pkg::REG_WDOG, 32'h0, "wdog");
    rc(ced_pkg::REG_STATUS, 32'h6, "wdog flags");
    ex(ced_pkg::OP_NOP, 1'b0);
    rc(ced_pkg::REG_PC, {17'h0, expPc}, "pc step");
    wr(ced_pkg::REG_FADDR, 32'h7F);
    wr(ced_pkg::REG_FDATA, 32'hFF);
    wr(ced_pkg::REG_WACC, 32'h55);
    ex(ced_pkg::OP_COMPL, 1'b0);
    rc(ced_pkg::REG_WACC, 32'h0, "compl acc");
    rc(ced_pkg::REG_FDATA, 32'hFF, "compl kept");
    rc(ced_pkg::REG_STATUS, 32'h7, "compl zero");
    ex(ced_pkg::OP_COMPL, 1'b1);
    rc(ced_pkg::REG_FDATA, 32'h0, "compl once");
    ex(ced_pkg::OP_COMPL, 1'b1);
    rc(ced_pkg::REG_FDATA, 32'hFF, "compl file");
    rc(ced_pkg::REG_STATUS, 32'h6, "compl nonzero");
    wr(ced_pkg::REG_FDATA, 32'h1);
    wr(ced_pkg::REG_WACC, 32'h55);
    ex(ced_pkg::OP_DEC_REG, 1'b0);
    rc(ced_pkg::REG_WACC, 32'h0, "dec acc");
    rc(ced_pkg::REG_STATUS, 32'h7, "dec zero");
    ex(ced_pkg::OP_DEC_REG, 1'b1);
    ex(ced_pkg::OP_DEC_REG, 1'b1);
    rc(ced_pkg::REG_FDATA, 32'hFF, "dec wrap");
    rc(ced_pkg::REG_STATUS, 32'h6, "dec nonzero");
    ex(ced_pkg::OP_CLR_REG, 1'b0);
    rc(ced_pkg::REG_FDATA, 32'h0, "clear file");
    rc(ced_pkg::REG_STATUS, 32'h7, "clear zero");
    wr(ced_pkg::REG_WACC, 32'h55);
    wr(ced_pkg::REG_STATUS, 32'h6);
    ex(ced_pkg::OP_CLR_ACC, 1'b0);
    rc(ced_pkg::REG_WACC, 32'h0, "clear acc");
    rc(ced_pkg::REG_STATUS, 32'h7, "clear acc zero");
    wr(ced_pkg::REG_FDATA, 32'h2);
    ex(ced_pkg::OP_DEC_SKIP, 1'b1);
    rc(ced_pkg::REG_FDATA, 32'h1, "skip file");
    rc(ced_pkg::REG_PC, {17'h0, expPc}, "no skip pc");
    wr(ced_pkg::REG_STATUS, 32'h6);
    wr(ced_pkg::REG_WACC, 32'h55);
    ex(ced_pkg::OP_DEC_SKIP, 1'b0);
    expPc = expPc + 15'h1;
    rc(ced_pkg::REG_PC, {17'h0, expPc}, "skip pc");
    rc(ced_pkg::REG_WACC, 32'h0, "skip acc");
    rc(ced_pkg::REG_STATUS, 32'h6, "skip flags");
    wr(ced_pkg::REG_PC, 32'h0123);
    wr(ced_pkg::REG_PCHI, 32'h5A);
    wr(ced_pkg::REG_WACC, 32'hC3);
    wr(ced_pkg::REG_STATUS, 32'h7);
    ex(ced_pkg::OP_CALL_ACC, 1'b0);
    rc(ced_pkg::REG_STACK, 32'h10124, "return");
    rc(ced_pkg::REG_PC, 32'h5AC3, "call pc");
    rc(ced_pkg::REG_STATUS, 32'h7, "call flags");
    print_verdict();
  end
endmodule
bind ced_exec_core ced_exec_chk u_chk (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp));
